// ==== hw/alm_core.v ====
// Purpose: axis lag supervision, jog speed select, feedhold and stop-rate choice
// Assumes: i_servo_tick is a one-cycle pulse per servo period; inputs synchronous
//          software never raises both register strobes in one cycle
// Notes: positions and speeds are signed 32-bit user units; the acceleration and stop rates are unsigned
//        the block only chooses speeds and rates; the profile generator ramps
//        trip and fault stay latched until software clears them in the control register
//
// Overview of operation
// - Rapid-jog selects axis speed, else jog rate
// - Rapid-jog select: off or 0-63, active low
// - Aborted moves stop at rapid-stop rate
// - Normal end or zero rate uses slowdown
// - Lag is demanded minus measured position
// - Capture lag only on loop-off fault trip
// - Captured lag clears when loop turns on
// - Trip flags condition word, default faults
// - Motion fault opens drive enable relay
// - Trip threshold resets to 2000 edges
// - Filter mode 1 needs two exceeding periods
// - Warning exceedance sets condition bit 1
// - Feedhold overrides speed, keeps the move
// - Hold speed changes ramp with rates
// - Hold release restores programmed speed
// - Non-speed moves ignore feedhold
// - Hold select: off or 0-63, active low
// - Hold speed resets to zero
//
// Limitations: one axis per instance; the speed and rate outputs are
// choices only, the ramp itself belongs to the profile generator; the
// select register keeps seven bits per field, so any value of 64 or more
// written there disables the function just as the all-ones value does.
// The lag is sampled only on the servo tick, so a spike that comes and
// goes between two ticks is never seen by the supervision.
//
// Implementation choices: strobed register access and the placing of the registers.
`include "alm_defines.vh"

module alm_core
(
    input wire i_sys_clk,
    input wire i_srst,
    // Servo period strobe: all supervision happens in this cycle only
    input wire i_servo_tick,
    // Plain register port; read data stands one cycle after the strobe
    input wire [`ALM_AW-1:0] i_addr,
    input wire [`ALM_DW-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [`ALM_DW-1:0] o_rdata,
    // Digital input lines, two of which may act as rapid-jog and feedhold
    input wire [63:0] i_inputs,
    // Positions from the profile generator and the encoder counter
    input wire signed [31:0] i_demanded_position,
    input wire signed [31:0] i_measured_position,
    // Move state from the profile generator
    input wire i_jog_active,
    input wire i_speed_move,
    input wire i_abort,
    // Speed and rate choices back to the profile generator
    output reg signed [31:0] o_target_speed,
    output reg signed [31:0] o_ramp_rate,
    output reg [31:0] o_stop_rate,
    // Relay, loop state and interrupt to the rest of the axis
    output reg o_drive_enable_relay,
    output reg o_loop_on,
    output wire o_irq
);

    // Software-programmed settings
    reg [`ALM_DW-1:0] ctrl_r;
    // Speeds and rates in user units per second, or per second squared
    reg signed [31:0] jog_rate_r;
    reg signed [31:0] speed_r;
    reg signed [31:0] hold_speed_r;
    reg [31:0] ramp_up_rate_r;
    reg [31:0] normal_slowdown_rate_r;
    reg [31:0] rapid_stop_rate_r;
    // Thresholds are magnitudes, compared strictly greater
    reg [31:0] lag_trip_threshold_r;
    reg [31:0] lag_warning_threshold_r;
    // Two 7-bit input selectors
    reg [`ALM_DW-1:0] select_r;

    // Supervision state
    reg signed [31:0] position_lag_r;
    reg signed [31:0] captured_lag_r;
    // Sticky trip and fault, warning following the lag
    reg trip_r;
    reg warn_r;
    reg fault_r;
    // Previous period's exceedance, for the two-period filter
    reg exceed_prev_r;

    // Interrupt status, mask and this cycle's events
    reg [`ALM_IRQ_W-1:0] irq_stat_r;
    reg [`ALM_IRQ_W-1:0] irq_mask_r;
    reg [`ALM_IRQ_W-1:0] irq_set;

    // Selector fields as stored; bits 7 and 15 are never kept
    wire [`ALM_SEL_W-1:0] jog_sel = select_r[`ALM_SEL_JOG_LO+`ALM_SEL_W-1:`ALM_SEL_JOG_LO];
    wire [`ALM_SEL_W-1:0] hold_sel = select_r[`ALM_SEL_HOLD_LO+`ALM_SEL_W-1:`ALM_SEL_HOLD_LO];
    wire loop_en = ctrl_r[`ALM_CTRL_LOOP_ON];

    // Write decodes shared by several processes
    wire wr_ctrl = i_wr && (i_addr == `ALM_REG_CTRL);
    wire wr_irq_stat = i_wr && (i_addr == `ALM_REG_IRQ_STAT);
    wire clr_fault = wr_ctrl && i_wdata[`ALM_CTRL_FAULT_CLR];
    wire [`ALM_IRQ_W-1:0] irq_clr = wr_irq_stat ? i_wdata[`ALM_IRQ_W-1:0] : {`ALM_IRQ_W{1'b0}};

    // Selected inputs are active low; the top select bit set means disabled.
    // A disabled selector never asserts, whatever the line it points at shows,
    // so an unused function cannot be woken by noise on a spare input
    wire rapid_jog = ~jog_sel[`ALM_SEL_W-1] & ~i_inputs[jog_sel[5:0]];
    wire hold_on = ~hold_sel[`ALM_SEL_W-1] & ~i_inputs[hold_sel[5:0]];

    // Lag and its magnitude, judged once per servo period.
    // The subtraction wraps like the position counters, so a lag beyond half
    // the signed range is not meaningful; the most negative lag has no
    // positive twin and reads as the largest magnitude, which still trips
    wire signed [31:0] lag_now = i_demanded_position - i_measured_position;
    wire [31:0] lag_mag = lag_now[31] ? (~lag_now + 32'h00000001) : lag_now;
    wire exceed = lag_mag > lag_trip_threshold_r;
    wire warn_now = lag_mag > lag_warning_threshold_r;
    // Mode 1 ignores a single-period spike at the cost of one period of delay
    // on a real runaway; exceed_prev_r holds the previous result even when
    // the filter is off, so switching modes takes effect at once
    wire trip_now = exceed & (~ctrl_r[`ALM_CTRL_FILTER] | exceed_prev_r);
    wire fault_now = trip_now & ctrl_r[`ALM_CTRL_FAULT_EN];
    // Loop-on is the 0 to 1 edge of the control bit as written by software
    wire loop_on_wr = wr_ctrl && i_wdata[`ALM_CTRL_LOOP_ON] && !loop_en;

    // Speed and ramp selection for the motion profile.
    // A running jog owns the speed; feedhold applies only to profiled moves,
    // so linked, cam and geared moves pass it by untouched.
    // Nothing is remembered across a hold: release simply returns to the
    // programmed speed, which software may have changed in the meantime
    always @*
    begin
        if (i_jog_active)
            o_target_speed = rapid_jog ? speed_r : jog_rate_r;
        else if (hold_on && i_speed_move)
            o_target_speed = hold_speed_r;
        else
            o_target_speed = speed_r;
        // Ramp up with acceleration, down with slowdown, hold changes included
        o_ramp_rate = (o_target_speed > speed_r) ? $signed(ramp_up_rate_r)
            : $signed(normal_slowdown_rate_r);
        // A zero rapid-stop rate means the option is unused, so aborts fall back
        if (i_abort && (rapid_stop_rate_r != 32'h00000000))
            o_stop_rate = rapid_stop_rate_r;
        else
            o_stop_rate = normal_slowdown_rate_r;
    end

    // Supervision state, updated on each servo tick.
    // Warning follows every tick; trip and fault are sticky so that software
    // sees why the loop dropped even after the lag has settled again.
    // A clear that meets a new trip in the same tick is lost on purpose
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            // The captured lag is cleared along with the flags
            position_lag_r <= 32'h00000000;
            captured_lag_r <= 32'h00000000;
            trip_r <= 1'b0;
            warn_r <= 1'b0;
            fault_r <= 1'b0;
            exceed_prev_r <= 1'b0;
        end
        else
        begin
            if (i_servo_tick)
            begin
                // The lag register holds the latest tick's value for software
                position_lag_r <= lag_now;
                exceed_prev_r <= exceed;
                warn_r <= warn_now;
                if (trip_now)
                    trip_r <= 1'b1;
                if (fault_now)
                    fault_r <= 1'b1;
                // Only the trip that drops the loop is kept, so later periods cannot overwrite it
                if (fault_now && loop_en)
                    captured_lag_r <= lag_now;
            end
            if (loop_on_wr)
                captured_lag_r <= 32'h00000000;
            if (clr_fault && !(i_servo_tick && trip_now))
            begin
                trip_r <= 1'b0;
                fault_r <= 1'b0;
            end
        end
    end

    // Register writes; a fault forces the position loop off.
    // Read-only and unmapped addresses are ignored; the clear bit of the control
    // register is not stored, so it reads back as zero and never clears twice
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            ctrl_r <= `ALM_CTRL_RST;
            // Rates reset to zero so no motion is asked for before software sets them
            jog_rate_r <= 32'h00000000;
            speed_r <= 32'h00000000;
            hold_speed_r <= 32'h00000000;
            ramp_up_rate_r <= 32'h00000000;
            normal_slowdown_rate_r <= 32'h00000000;
            rapid_stop_rate_r <= 32'h00000000;
            lag_trip_threshold_r <= `ALM_TRIP_THR_RST;
            lag_warning_threshold_r <= `ALM_TRIP_THR_RST;
            select_r <= `ALM_SELECT_RST;
            irq_mask_r <= {`ALM_IRQ_W{1'b0}};
        end
        else
        begin
            if (i_wr)
            begin
                if (i_addr == `ALM_REG_CTRL)
                    ctrl_r <= {28'h0000000, 1'b0, i_wdata[`ALM_CTRL_FAULT_EN:0]};
                else if (i_addr == `ALM_REG_JOG_RATE)
                    jog_rate_r <= i_wdata;
                else if (i_addr == `ALM_REG_SPEED)
                    speed_r <= i_wdata;
                else if (i_addr == `ALM_REG_HOLD_SPEED)
                    hold_speed_r <= i_wdata;
                else if (i_addr == `ALM_REG_RAMP_UP)
                    ramp_up_rate_r <= i_wdata;
                else if (i_addr == `ALM_REG_SLOWDOWN)
                    normal_slowdown_rate_r <= i_wdata;
                else if (i_addr == `ALM_REG_RAPID_STOP)
                    rapid_stop_rate_r <= i_wdata;
                else if (i_addr == `ALM_REG_TRIP_THR)
                    lag_trip_threshold_r <= i_wdata;
                else if (i_addr == `ALM_REG_WARN_THR)
                    lag_warning_threshold_r <= i_wdata;
                else if (i_addr == `ALM_REG_SELECT)
                    select_r <= {17'h00000, i_wdata[`ALM_SEL_HOLD_LO+`ALM_SEL_W-1:`ALM_SEL_HOLD_LO], 1'b0,
                        i_wdata[`ALM_SEL_JOG_LO+`ALM_SEL_W-1:`ALM_SEL_JOG_LO]};
                else if (i_addr == `ALM_REG_IRQ_MASK)
                    irq_mask_r <= i_wdata[`ALM_IRQ_W-1:0];
            end
            // Fault wins over a same-cycle software loop-on request
            if (i_servo_tick && fault_now)
                ctrl_r[`ALM_CTRL_LOOP_ON] <= 1'b0;
        end
    end

    // Interrupt events: rising trip, warning entry, fault entry.
    // Events are edges of the supervision flags so that a lasting condition
    // raises one interrupt, not one per servo period
    always @*
    begin
        irq_set = {`ALM_IRQ_W{1'b0}};
        irq_set[`ALM_IRQ_TRIP] = i_servo_tick & trip_now & ~trip_r;
        irq_set[`ALM_IRQ_WARN] = i_servo_tick & warn_now & ~warn_r;
        irq_set[`ALM_IRQ_FAULT] = i_servo_tick & fault_now & ~fault_r;
    end

    // Sticky status, write one to clear, one flop per event bit.
    // A new event wins over a same-cycle clear, so no event is ever lost
    genvar gi;
    generate
        for (gi = 0; gi < `ALM_IRQ_W; gi = gi + 1)
        begin : g_irq_bit
            always @(posedge i_sys_clk)
            begin
                if (i_srst)
                    irq_stat_r[gi] <= 1'b0;
                else if (irq_set[gi])
                    irq_stat_r[gi] <= 1'b1;
                else if (irq_clr[gi])
                    irq_stat_r[gi] <= 1'b0;
            end
        end
    endgenerate

    // Level interrupt: high while any unmasked status bit is set
    assign o_irq = |(irq_stat_r & irq_mask_r);

    // Condition word, assembled by named bit position
    wire [3:0] cond_word;
    assign cond_word[`ALM_COND_TRIP] = trip_r;
    assign cond_word[`ALM_COND_WARN] = warn_r;
    assign cond_word[`ALM_COND_FAULT] = fault_r;
    assign cond_word[`ALM_COND_HOLD] = hold_on;

    // Registered outputs and read data, one cycle after the strobe.
    // The relay follows the fault flag one cycle late; that cycle is the price
    // of driving the relay from a flop rather than from decode logic.
    // Read data fall back to zero outside their cycle so that several
    // slaves on one bus can simply have their returns ORed together
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_rdata <= 32'h00000000;
            o_drive_enable_relay <= 1'b0;
            o_loop_on <= 1'b0;
        end
        else
        begin
            o_drive_enable_relay <= ~fault_r;
            o_loop_on <= loop_en;
            if (!i_rd)
                o_rdata <= 32'h00000000;
            else if (i_addr == `ALM_REG_CTRL)
                o_rdata <= ctrl_r;
            else if (i_addr == `ALM_REG_JOG_RATE)
                o_rdata <= jog_rate_r;
            else if (i_addr == `ALM_REG_SPEED)
                o_rdata <= speed_r;
            else if (i_addr == `ALM_REG_HOLD_SPEED)
                o_rdata <= hold_speed_r;
            else if (i_addr == `ALM_REG_RAMP_UP)
                o_rdata <= ramp_up_rate_r;
            else if (i_addr == `ALM_REG_SLOWDOWN)
                o_rdata <= normal_slowdown_rate_r;
            else if (i_addr == `ALM_REG_RAPID_STOP)
                o_rdata <= rapid_stop_rate_r;
            else if (i_addr == `ALM_REG_TRIP_THR)
                o_rdata <= lag_trip_threshold_r;
            else if (i_addr == `ALM_REG_WARN_THR)
                o_rdata <= lag_warning_threshold_r;
            else if (i_addr == `ALM_REG_SELECT)
                o_rdata <= select_r;
            else if (i_addr == `ALM_REG_LAG)
                o_rdata <= position_lag_r;
            else if (i_addr == `ALM_REG_CAPTURED)
                o_rdata <= captured_lag_r;
            else if (i_addr == `ALM_REG_COND)
                o_rdata <= {28'h0000000, cond_word};
            else if (i_addr == `ALM_REG_IRQ_STAT)
                o_rdata <= {29'h00000000, irq_stat_r};
            else if (i_addr == `ALM_REG_IRQ_MASK)
                o_rdata <= {29'h00000000, irq_mask_r};
            else
                o_rdata <= 32'h00000000; // Unmapped reads return zero
        end
    end

endmodule

// ==== hw/alm_defines.vh ====
// Purpose: constants for the axis lag monitor and speed select block
// Assumes: included by hw/alm_core.v only
// Notes: register offsets are word addresses on the plain register port
`ifndef ALM_DEFINES_VH
`define ALM_DEFINES_VH

`define ALM_AW 4
`define ALM_DW 32
`define ALM_SEL_W 7

// Register offsets
`define ALM_REG_CTRL 4'h0
`define ALM_REG_JOG_RATE 4'h1
`define ALM_REG_SPEED 4'h2
`define ALM_REG_HOLD_SPEED 4'h3
`define ALM_REG_RAMP_UP 4'h4
`define ALM_REG_SLOWDOWN 4'h5
`define ALM_REG_RAPID_STOP 4'h6
`define ALM_REG_TRIP_THR 4'h7
`define ALM_REG_WARN_THR 4'h8
`define ALM_REG_SELECT 4'h9
`define ALM_REG_LAG 4'hA
`define ALM_REG_CAPTURED 4'hB
`define ALM_REG_COND 4'hC
`define ALM_REG_IRQ_STAT 4'hD
`define ALM_REG_IRQ_MASK 4'hE

// Control register fields
`define ALM_CTRL_LOOP_ON 0
`define ALM_CTRL_FILTER 1
`define ALM_CTRL_FAULT_EN 2
`define ALM_CTRL_FAULT_CLR 3

// Select register fields: rapid-jog select in [6:0], hold select in [14:8]
`define ALM_SEL_JOG_LO 0
`define ALM_SEL_HOLD_LO 8
`define ALM_SEL_OFF 7'h7F

// Condition word bits
`define ALM_COND_TRIP 0
`define ALM_COND_WARN 1
`define ALM_COND_FAULT 2
`define ALM_COND_HOLD 3

// Interrupt status bits
`define ALM_IRQ_TRIP 0
`define ALM_IRQ_WARN 1
`define ALM_IRQ_FAULT 2
`define ALM_IRQ_W 3

// Reset values
`define ALM_TRIP_THR_RST 32'h000007D0
`define ALM_CTRL_RST 32'h00000004
`define ALM_SELECT_RST 32'h00007F7F

`endif

// ==== tb/alm_core_sva.sv ====
// Purpose: port-level checks for the lag monitor and speed select block
// Assumes: registers change only through the plain register port
// Notes: a write mirror lets the checks see the programmed values
module alm_chk
(
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_servo_tick,
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    input wire [63:0] i_inputs,
    input wire signed [31:0] i_demanded_position,
    input wire signed [31:0] i_measured_position,
    input wire i_jog_active,
    input wire i_speed_move,
    input wire i_abort,
    input wire signed [31:0] o_target_speed,
    input wire [31:0] o_stop_rate,
    input wire o_drive_enable_relay,
    input wire o_loop_on,
    input wire o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rg_r [0:15];
    logic prev_ex_r;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    // Magnitude of the lag against the programmed trip threshold
    wire signed [31:0] lag = i_demanded_position - i_measured_position;
    wire [31:0] mag = lag[31] ? -lag : lag;
    wire ex = mag > rg_r[7];
    wire trip = ex && (!rg_r[0][1] || prev_ex_r);
    wire hold_on = !rg_r[9][14] && !i_inputs[rg_r[9][13:8]];
    wire fast_on = !rg_r[9][6] && !i_inputs[rg_r[9][5:0]];

    // Mirror of written values; exceedance remembered per tick for the filter
    always_ff @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            for (int k = 0; k < 16; k++)
                rg_r[k] <= 32'h0;
            rg_r[0] <= 32'h4;
            rg_r[7] <= 32'h7D0;
            rg_r[8] <= 32'h7D0;
            rg_r[9] <= 32'h7F7F;
            prev_ex_r <= 1'b0;
        end
        else
        begin
            if (i_wr)
                rg_r[i_addr] <= i_wdata;
            if (i_servo_tick)
                prev_ex_r <= ex;
        end
    end

    a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> !o_loop_on && !o_irq)
        else $error("loop or interrupt active after reset");
    a_relay_reset: assert property (disable iff (1'b0) i_srst ##1 !i_srst |->
        !o_drive_enable_relay ##1 o_drive_enable_relay)
        else $error("relay not closed on time after reset");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_stop_choice: assert property (o_stop_rate == ((i_abort && rg_r[6] != 0) ? rg_r[6] : rg_r[5]))
        else $error("wrong stopping rate");
    a_speed_pick: assert property (o_target_speed == (i_jog_active ? (fast_on ? rg_r[2] : rg_r[1]) :
        ((hold_on && i_speed_move) ? rg_r[3] : rg_r[2])))
        else $error("wrong target speed");
    a_trip_opens_relay: assert property (i_servo_tick && trip && rg_r[0][2] && !i_wr |->
        ##2 (!o_loop_on && !o_drive_enable_relay))
        else $error("trip did not open the relay");
    a_filter_skip: assert property (i_servo_tick && ex && rg_r[0][1] && !prev_ex_r && o_loop_on && !i_wr
        |-> ##2 o_loop_on)
        else $error("single exceeding period tripped");
    a_irq_masked: assert property (rg_r[14][2:0] == 3'h0 |-> !o_irq)
        else $error("masked interrupt raised");
endmodule

bind alm_core alm_chk u_chk (.*);

// ==== tb/alm_far_model.sv ====
// Purpose: behavioural axis side: demand, encoder and digital input lines
// Assumes: lag and low lines are set by the bench between servo ticks
// Notes: released input lines read high, as through a pull-up
module alm_far_model
(
    input wire i_clk,
    input wire signed [31:0] i_lag,
    input wire [63:0] i_low,
    output logic signed [31:0] o_dem,
    output wire signed [31:0] o_meas,
    output wire [63:0] o_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // Demand creeps forward so the lag is taken on a moving axis
    initial o_dem = 32'sh100;
    always @(posedge i_clk)
        o_dem <= o_dem + 32'sh3;
    // Encoder trails the demand by the commanded lag
    assign o_meas = o_dem - i_lag;
    // Lines pulled low are active; the rest float high
    assign o_lines = ~i_low;
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the lag monitor and speed select block
// Assumes: alm_far_model drives axis positions and input lines
// Notes: reads queue their expected word; a monitor compares it a cycle later
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string nm; logic [31:0] v;} alm_exp_t;
    alm_exp_t exp_q[$];
    alm_exp_t e;
    logic i_sys_clk = 0, i_srst = 1, i_servo_tick = 0, i_wr = 0, i_rd = 0, rd_q = 0;
    logic i_jog_active = 0, i_speed_move = 0, i_abort = 0, o_drive_enable_relay, o_loop_on, o_irq;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata, o_stop_rate, rnd = 32'h5;
    logic signed [31:0] o_target_speed, o_ramp_rate, dem, meas, lag = 0;
    logic [63:0] low = 64'h0, lines;
    logic [31:0] want;
    int num_errors = 0, n_compared = 0;

    always #2.5 i_sys_clk = ~i_sys_clk;
    alm_far_model far (.i_clk(i_sys_clk), .i_lag(lag), .i_low(low), .o_dem(dem), .o_meas(meas), .o_lines(lines));
    alm_core dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_servo_tick(i_servo_tick), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_inputs(lines),
        .i_demanded_position(dem), .i_measured_position(meas), .i_jog_active(i_jog_active),
        .i_speed_move(i_speed_move), .i_abort(i_abort), .o_target_speed(o_target_speed),
        .o_ramp_rate(o_ramp_rate), .o_stop_rate(o_stop_rate), .o_drive_enable_relay(o_drive_enable_relay),
        .o_loop_on(o_loop_on), .o_irq(o_irq));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // Each access leaves one idle edge so no strobe is driven twice in a step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_wr <= 1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] v, input string nm);
        exp_q.push_back('{nm, v});
        i_rd <= 1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 0;
        @(posedge i_sys_clk);
    endtask
    task automatic tick;
        i_servo_tick <= 1;
        @(posedge i_sys_clk);
        i_servo_tick <= 0;
        @(posedge i_sys_clk);
    endtask
    task automatic tally_and_finish;
        $display("Mismatches %0d in %0d comparisons", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe; take the oldest note then
    always @(posedge i_sys_clk)
    begin
        rd_q <= i_rd;
        if (rd_q && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check(e.nm, o_rdata, e.v);
        end
    end

    // Watchdog, far beyond the hundred or so cycles the sequence needs
    initial
    begin
        #20000;
        num_errors++;
        tally_and_finish;
    end

    initial
    begin
        repeat (6) @(posedge i_sys_clk);
        i_srst <= 0;
        @(posedge i_sys_clk);
        rd(4'h0, 32'h4, "ctrl");
        rd(4'h7, 32'h7D0, "trip_thr");
        rd(4'h3, 32'h0, "hold_speed");
        rd(4'h9, 32'h7F7F, "select");
        rd(4'hF, 32'h0, "unmapped");
        // Rates, then both stopping cases: zero rapid rate falls back to slowdown
        wr(4'h1, 32'h2BC);
        wr(4'h2, 32'h1F4);
        wr(4'h3, 32'h32);
        wr(4'h4, 32'h3E8);
        wr(4'h5, 32'h14);
        i_abort <= 1;
        @(posedge i_sys_clk);
        check("stop_unset", o_stop_rate, 32'h14);
        wr(4'h6, 32'h12C);
        check("stop_rapid", o_stop_rate, 32'h12C);
        i_abort <= 0;
        @(posedge i_sys_clk);
        check("stop_normal", o_stop_rate, 32'h14);
        // Rapid jog on line 12, hold on line 5; every mix of jog, rapid, hold, move kind
        wr(4'h9, 32'h050C);
        for (int k = 0; k < 16; k++)
        begin
            rnd = xs(rnd);
            low <= ({rnd, ~rnd} & ~64'h1020) | (64'(k[1]) << 12) | (64'(k[2]) << 5);
            i_jog_active <= k[0];
            i_speed_move <= k[3];
            @(posedge i_sys_clk);
            want = k[0] ? (k[1] ? 32'h1F4 : 32'h2BC) : ((k[2] && k[3]) ? 32'h32 : 32'h1F4);
            check("target", o_target_speed, want);
            check("ramp", o_ramp_rate, (want > 32'h1F4) ? 32'h3E8 : 32'h14);
        end
        low <= 64'h0;
        // Lag between the warning and trip levels
        wr(4'h8, 32'h64);
        wr(4'h7, 32'h3E8);
        wr(4'hE, 32'h7);
        wr(4'h0, 32'h5);
        rnd = xs(rnd);
        lag <= 32'h65 + rnd % 32'h383;
        tick;
        rd(4'hA, lag, "lag");
        rd(4'hC, 32'h2, "cond_warn");
        check("irq", o_irq, 1'b1);
        lag <= 0;
        tick;
        wr(4'hD, 32'h7);
        check("irq", o_irq, 1'b0);
        // Filter mode: one exceeding period is ignored, two in a row trip
        wr(4'h0, 32'h7);
        lag <= -32'sh4B0;
        tick;
        lag <= 0;
        tick;
        rd(4'hC, 32'h0, "cond_single");
        lag <= -32'sh4B0;
        tick;
        tick;
        rd(4'hC, 32'h7, "cond_trip");
        rd(4'hB, -32'sh4B0, "captured");
        rd(4'hD, 32'h7, "irq_stat");
        lag <= 0;
        wr(4'h0, 32'hD);
        rd(4'hB, 32'h0, "captured_clr");
        // Immediate mode at the threshold and one past it
        lag <= 32'h3E8;
        tick;
        rd(4'hC, 32'h2, "cond_equal");
        lag <= 32'h3E9;
        tick;
        rd(4'hC, 32'h7, "cond_over");
        // Reset again in mid-run
        i_srst <= 1;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 0;
        @(posedge i_sys_clk);
        rd(4'h7, 32'h7D0, "trip_thr");
        repeat (3) @(posedge i_sys_clk);
        tally_and_finish;
    end
endmodule
